// *** common/regbank_consts.vh ***
// Constants for the register access bank: offsets, field layout, resets, ranges
`ifndef REGBANK_CONSTS_VH
`define REGBANK_CONSTS_VH

// Word offsets (byte addresses) of the implemented words
`define OFS_MIXED 8'h00
`define OFS_GATED 8'h04
`define OFS_KEEP 8'h08
`define OFS_PROT 8'h0c

// Address ranges: implemented, quiet (no error) and erroring
`define IMPL_TOP 8'h3f
`define QUIET_TOP 8'h7f

// Transfer sizes on the access port
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

// Mixed word field layout
`define RW_LSB 0
`define RW_MSB 7
`define RWH_LSB 8
`define RWH_MSB 15
`define RO_LSB 16
`define RO_MSB 19
`define WO_LSB 20
`define WO_MSB 23
`define RH_LSB 24
`define RH_MSB 27

// Per-bit classes of the mixed word
`define MIX_SW_MASK 32'h00ffffff
`define MIX_HW_MASK 32'h0f00ff00
`define MIX_STORE_MASK 32'h0f00ffff
`define MIX_RD_MASK 32'h0f00ffff
`define MIX_RO_MASK 32'h000f0000

// Read-back value of write-only bits
`define WO_DFLT 4'h0

// Reset values and access masks
`define MIX_RST 32'h00000000
`define GATED_RST 32'h00000000
`define KEEP_RST 32'h00000000
`define PROT_RST 32'h00000001
`define FULL_MASK 32'hffffffff
`define NO_MASK 32'h00000000
`define PROT_MASK 32'h00000001

`endif

// *** rtl/reg_word.v ***
// One stored register word with per-bit software and hardware access classes
`default_nettype none
`include "regbank_consts.vh"

module reg_word #(
    parameter [31:0] SW_MASK = 32'hffffffff,
    parameter [31:0] HW_MASK = 32'h00000000,
    parameter [31:0] RST_VAL = 32'h00000000,
    parameter KEEP = 0
) (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Bank-wide clear to defaults
    input wire soft_clr,
    // Software write
    input wire wr_en,
    input wire [3:0] byte_en,
    input wire [31:0] wdata,
    // Hardware update
    input wire [31:0] hw_set,
    input wire [31:0] hw_clr,
    // Stored value
    output reg [31:0] q_r
);

    reg [31:0] lane_mask;
    reg [31:0] hw_nxt;
    reg [31:0] q_nxt;

    // Hardware acts first, a software write overrides it lane by lane
    always @* begin
        lane_mask = {{8{byte_en[3]}}, {8{byte_en[2]}}, {8{byte_en[1]}}, {8{byte_en[0]}}};
        hw_nxt = (q_r | (hw_set & HW_MASK)) & ~(hw_clr & HW_MASK);
        q_nxt = hw_nxt;
        if (wr_en) begin
            // Software wins the conflict on bits it may write
            q_nxt = (hw_nxt & ~(lane_mask & SW_MASK)) | (wdata & lane_mask & SW_MASK);
        end
        if (soft_clr && (KEEP == 0)) begin
            q_nxt = RST_VAL;
        end
    end

    always @(posedge mclk) begin
        if (!rst_b) begin
            q_r <= RST_VAL;
        end else begin
            q_r <= q_nxt;
        end
    end

endmodule
`default_nettype wire

// *** rtl/regbank.v ***
// Register bank access layer: field classes, range attributes and protection gate
//
// Overview of operation
// - Read-write bits return stored value and take software writes.
// - Hardware may set or clear rwh bits; software write wins on conflict.
// - Read-only bits ignore writes and only supply their value.
// - Write-only bits accept writes but always read a fixed default.
// - Status bits change by hardware only; writes leave them alone.
// - Word-only registers take full 32-bit transfers; master must not narrow them.
// - Accesses into an erroring range answer with a bus error.
// - Accesses into an error-free range complete without error, even unimplemented, unless misaligned, of undefined size or narrow to a word-only register.
// - An unchanged register keeps its contents through the bank clear.
// - Gated registers take writes only while protection is off.
// - Reserved and unimplemented bits always read back zero.
// - Only the privileged level exists; accesses are never refused by level.
`default_nettype none
`include "regbank_consts.vh"

module regbank (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Access port from the processor core
    input wire bus_req,
    input wire bus_wr,
    input wire [7:0] bus_addr,
    input wire [1:0] bus_size,
    input wire [31:0] bus_wdata,
    output reg [31:0] bus_rdata_r,
    output reg bus_ack_r,
    output reg bus_err_r,
    // Hardware side of the mixed word
    input wire [7:0] rwh_set,
    input wire [7:0] rwh_clr,
    input wire [3:0] ro_val,
    input wire [3:0] stat_set,
    input wire [3:0] stat_clr,
    input wire soft_clr,
    // Register contents towards the functions
    output reg [7:0] ctrl_rw_r,
    output reg [7:0] ctrl_rwh_r,
    output reg [3:0] stat_r,
    output reg [3:0] wo_val_r,
    output reg wo_strobe_r,
    output reg [31:0] gated_cfg_r,
    output reg [31:0] keep_val_r,
    output reg protection_gated_r
);

    // Byte enables of a transfer; misaligned halves get none
    function [3:0] lanes;
        input [1:0] size;
        input [1:0] low;
        begin
            case (size)
                `SIZE_BYTE: lanes = 4'h1 << low;
                `SIZE_HALF: lanes = low[0] ? 4'h0 : (low[1] ? 4'hc : 4'h3);
                `SIZE_WORD: lanes = (low == 2'h0) ? 4'hf : 4'h0;
                default: lanes = 4'h0;
            endcase
        end
    endfunction

    // Word select of an implemented offset
    function hit;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            hit = (addr[7:2] == ofs[7:2]);
        end
    endfunction

    wire [31:0] mix_q;
    wire [31:0] gated_q;
    wire [31:0] keep_q;
    wire [31:0] prot_q;
    reg [3:0] be;
    reg sel_mix;
    reg sel_gated;
    reg sel_keep;
    reg sel_prot;
    reg in_impl;
    reg in_quiet;
    reg word_only;
    reg acc_err;
    reg wr_ok;
    reg [31:0] rd_nxt;
    reg [31:0] mix_hw_set;
    reg [31:0] mix_hw_clr;

    // Decode of every transfer against range and word attributes
    always @* begin
        be = lanes(bus_size, bus_addr[1:0]);
        in_impl = (bus_addr <= `IMPL_TOP);
        in_quiet = !in_impl && (bus_addr <= `QUIET_TOP);
        sel_mix = in_impl && hit(bus_addr, `OFS_MIXED);
        sel_gated = in_impl && hit(bus_addr, `OFS_GATED);
        sel_keep = in_impl && hit(bus_addr, `OFS_KEEP);
        sel_prot = in_impl && hit(bus_addr, `OFS_PROT);
        // Word-only words refuse narrower transfers so a half write never lands
        word_only = sel_gated || sel_prot;
        acc_err = 1'b0;
        if (!in_impl && !in_quiet) begin
            acc_err = 1'b1;
        end else if (be == 4'h0) begin
            acc_err = 1'b1;
        end else if (word_only && (bus_size != `SIZE_WORD)) begin
            acc_err = 1'b1;
        end
        // No privilege check: every access runs at the one privileged level
        wr_ok = bus_req && bus_wr && !acc_err;
    end

    // Read data assembly; reserved, write-only and quiet bits return zero
    always @* begin
        rd_nxt = 32'h00000000;
        if (sel_mix) begin
            rd_nxt = mix_q & `MIX_RD_MASK;
            rd_nxt[`RO_MSB:`RO_LSB] = ro_val;
            rd_nxt[`WO_MSB:`WO_LSB] = `WO_DFLT;
        end else if (sel_gated) begin
            rd_nxt = gated_q;
        end else if (sel_keep) begin
            rd_nxt = keep_q;
        end else if (sel_prot) begin
            rd_nxt = prot_q & `PROT_MASK;
        end
    end

    // Hardware update vectors of the mixed word
    always @* begin
        mix_hw_set = 32'h00000000;
        mix_hw_clr = 32'h00000000;
        mix_hw_set[`RWH_MSB:`RWH_LSB] = rwh_set;
        mix_hw_clr[`RWH_MSB:`RWH_LSB] = rwh_clr;
        mix_hw_set[`RH_MSB:`RH_LSB] = stat_set;
        mix_hw_clr[`RH_MSB:`RH_LSB] = stat_clr;
    end

    // Mixed word: rw, rwh, ro, wo and status bits; only rw/rwh/wo/status lanes stored
    reg_word #(
        .SW_MASK(`MIX_SW_MASK & ~`MIX_RO_MASK),
        .HW_MASK(`MIX_HW_MASK),
        .RST_VAL(`MIX_RST),
        .KEEP(0)
    ) u_mix (
        .mclk(mclk),
        .rst_b(rst_b),
        .soft_clr(soft_clr),
        .wr_en(wr_ok && sel_mix),
        .byte_en(be),
        .wdata(bus_wdata),
        .hw_set(mix_hw_set),
        .hw_clr(mix_hw_clr),
        .q_r(mix_q)
    );

    // Gated word: a write while protection is on completes but is dropped
    reg_word #(
        .SW_MASK(`FULL_MASK),
        .HW_MASK(`NO_MASK),
        .RST_VAL(`GATED_RST),
        .KEEP(0)
    ) u_gated (
        .mclk(mclk),
        .rst_b(rst_b),
        .soft_clr(soft_clr),
        .wr_en(wr_ok && sel_gated && !prot_q[0]),
        .byte_en(be),
        .wdata(bus_wdata),
        .hw_set(32'h00000000),
        .hw_clr(32'h00000000),
        .q_r(gated_q)
    );

    // Unchanged word: the bank clear passes it by
    reg_word #(
        .SW_MASK(`FULL_MASK),
        .HW_MASK(`NO_MASK),
        .RST_VAL(`KEEP_RST),
        .KEEP(1)
    ) u_keep (
        .mclk(mclk),
        .rst_b(rst_b),
        .soft_clr(soft_clr),
        .wr_en(wr_ok && sel_keep),
        .byte_en(be),
        .wdata(bus_wdata),
        .hw_set(32'h00000000),
        .hw_clr(32'h00000000),
        .q_r(keep_q)
    );

    // Protection control: bit 0 set means gated writes are blocked
    reg_word #(
        .SW_MASK(`PROT_MASK),
        .HW_MASK(`NO_MASK),
        .RST_VAL(`PROT_RST),
        .KEEP(0)
    ) u_prot (
        .mclk(mclk),
        .rst_b(rst_b),
        .soft_clr(soft_clr),
        .wr_en(wr_ok && sel_prot),
        .byte_en(be),
        .wdata(bus_wdata),
        .hw_set(32'h00000000),
        .hw_clr(32'h00000000),
        .q_r(prot_q)
    );

    // Answer one cycle after the request; error replaces data
    always @(posedge mclk) begin
        if (!rst_b) begin
            bus_ack_r <= 1'b0;
            bus_err_r <= 1'b0;
            bus_rdata_r <= 32'h00000000;
        end else begin
            bus_ack_r <= bus_req;
            bus_err_r <= bus_req && acc_err;
            bus_rdata_r <= (bus_req && !bus_wr && !acc_err) ? rd_nxt : 32'h00000000;
        end
    end

    // Copies towards the functions; outputs stay flop-driven
    always @(posedge mclk) begin
        if (!rst_b) begin
            ctrl_rw_r <= 8'h00;
            ctrl_rwh_r <= 8'h00;
            stat_r <= 4'h0;
            wo_val_r <= 4'h0;
            wo_strobe_r <= 1'b0;
            gated_cfg_r <= `GATED_RST;
            keep_val_r <= `KEEP_RST;
            protection_gated_r <= 1'b1;
        end else begin
            ctrl_rw_r <= mix_q[`RW_MSB:`RW_LSB];
            ctrl_rwh_r <= mix_q[`RWH_MSB:`RWH_LSB];
            stat_r <= mix_q[`RH_MSB:`RH_LSB];
            wo_val_r <= mix_q[`WO_MSB:`WO_LSB];
            // Pulse when the write-only lane was written
            wo_strobe_r <= wr_ok && sel_mix && be[2];
            gated_cfg_r <= gated_q;
            keep_val_r <= keep_q;
            protection_gated_r <= prot_q[0];
        end
    end

endmodule
`default_nettype wire

// *** tb/regbank_chk.sv ***
// Port checker for the register access bank
`default_nettype none
`include "regbank_consts.vh"
module regbank_chk (
    // Clock and reset
    input wire mclk,
    input wire rst_b,
    // Access port
    input wire bus_req,
    input wire bus_wr,
    input wire [7:0] bus_addr,
    input wire [1:0] bus_size,
    input wire [31:0] bus_rdata_r,
    input wire bus_ack_r,
    input wire bus_err_r,
    // Hardware side and contents
    input wire [3:0] ro_val,
    input wire [3:0] stat_set,
    input wire [3:0] stat_clr,
    input wire soft_clr,
    input wire [3:0] stat_r,
    input wire [31:0] gated_cfg_r,
    input wire [31:0] keep_val_r,
    input wire protection_gated_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Word read of the mixed word, and a gated write while protection is known on
    wire rd0 = bus_req && !bus_wr && bus_addr == `OFS_MIXED && bus_size == `SIZE_WORD;
    wire wg = bus_req && bus_wr && bus_addr == `OFS_GATED && protection_gated_r && !soft_clr;
    wire wp = bus_req && bus_wr && bus_addr == `OFS_PROT;

    a_ack_follows: assert property (bus_ack_r == $past(bus_req))
        else $error("answer does not follow request");
    a_err_outside: assert property (bus_req && (bus_addr[7] || bus_size == 2'h3) |=> bus_err_r)
        else $error("no error outside the map");
    a_word_only: assert property (bus_req && bus_addr[7:4] == 4'h0 && bus_addr[2]
        && bus_size != `SIZE_WORD |=> bus_err_r)
        else $error("narrow access to word-only register passed");
    a_quiet_range: assert property (bus_req && bus_addr[7:6] == 2'h1 && bus_addr[1:0] == 2'h0
        && bus_size == `SIZE_WORD |=> !bus_err_r && bus_ack_r)
        else $error("error in quiet range");
    a_unused_zero: assert property (bus_req && !bus_wr && bus_addr[7:4] != 4'h0
        |=> bus_rdata_r == 32'h0)
        else $error("unimplemented place read nonzero");
    a_ro_shown: assert property (rd0 |=> bus_rdata_r[19:16] == $past(ro_val))
        else $error("read-only field not shown");
    a_wo_dflt: assert property (rd0 |=> bus_rdata_r[23:20] == `WO_DFLT
        && bus_rdata_r[31:28] == 4'h0)
        else $error("write-only or reserved bits read back");
    a_stat_hw_only: assert property (!soft_clr && stat_set == 4'h0 && stat_clr == 4'h0
        |-> ##2 $stable(stat_r))
        else $error("status moved without hardware");
    a_gate_holds: assert property (wg && !$past(wp) |-> ##2 $stable(gated_cfg_r))
        else $error("gated write taken while protected");
    a_keep_clr: assert property (soft_clr && !bus_req |-> ##2 $stable(keep_val_r))
        else $error("unchanged word altered by clear");
    c_gated_drop: cover property (wg);
    c_soft_clr: cover property (soft_clr);
    c_err: cover property (bus_err_r);
endmodule
`default_nettype wire

// *** tb/core_model.sv ***
// Processor core model issuing single transfers to the bank
`default_nettype none
module core_model (
    // Clock
    input wire logic mclk,
    // Transfer request
    output logic bus_req,
    output logic bus_wr,
    output logic [7:0] bus_addr,
    output logic [1:0] bus_size,
    output logic [31:0] bus_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {bus_req, bus_wr, bus_addr, bus_size, bus_wdata} = 44'h0;
    // One request cycle per transfer; no privilege qualifier exists to send
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [1:0] s,
                        input logic [31:0] d);
        @(posedge mclk);
        {bus_req, bus_wr, bus_addr, bus_size, bus_wdata} <= {1'h1, wr, a, s, d};
        @(posedge mclk);
        // Released lines carry the inverse so a stale value never looks valid
        {bus_req, bus_wr, bus_addr, bus_size, bus_wdata} <= {1'h0, ~wr, ~a, ~s, ~d};
    endtask
endmodule
`default_nettype wire

// *** tb/regbank_tb_top.sv ***
// Bench for the register access bank with a reference store model
`default_nettype none
`include "regbank_consts.vh"
module regbank_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'h0, rst_b = 1'h0, soft_clr = 1'h0, hw_on = 1'h0;
    logic bus_req, bus_wr, bus_ack_r, bus_err_r, wo_strobe_r, protection_gated_r, prt, pprt, e;
    logic [1:0] bus_size, s;
    logic [3:0] ro_val = 4'h0, stat_set = 4'h0, stat_clr = 4'h0, stat_r, wo_val_r, wo, pwo;
    logic [7:0] bus_addr, rwh_set = 8'h0, rwh_clr = 8'h0, ctrl_rw_r, ctrl_rwh_r, a;
    logic [31:0] bus_wdata, bus_rdata_r, gated_cfg_r, keep_val_r, mix, gat, kep, pmix, pgat, pkep;
    logic [31:0] m, rd;
    logic wsp;
    logic [32:0] expq[$];
    logic [7:0] pick[8] = '{8'h00, 8'h02, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h40, 8'h80};
    int seed = 76, n_fail = 0, checks = 0, up = 0, i;

    regbank DUT (.*);
    core_model core (.*);

    always #20 mclk = ~mclk;

    // Hardware side moves at random; clear and set often collide on purpose
    always @(posedge mclk) begin
        ro_val <= 4'($random(seed));
        {rwh_set, rwh_clr, stat_set, stat_clr} <= hw_on ? 24'($random(seed)) : 24'h0;
    end

    task note(input string msg);
        n_fail++;
        $display("[ERR] %0t %s", $time, msg);
    endtask
    task cmp_bus(input logic [32:0] got, input logic [32:0] exp);
        checks++;
        if (got !== exp) note($sformatf("answer %h expected %h", got, exp));
    endtask
    task cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) note($sformatf("outputs %h expected %h", got, exp));
    endtask
    task complete_run;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    function automatic logic bad(logic [7:0] ad, logic [1:0] sz);
        bad = ad[7] || sz == 2'h3 || (sz == 2'h1 && ad[0]) || (sz == 2'h2 && ad[1:0] != 2'h0)
              || (ad[7:4] == 4'h0 && ad[2] && sz != 2'h2);
    endfunction
    function automatic logic [31:0] lanes(logic [7:0] ad, logic [1:0] sz);
        lanes = sz == 2'h2 ? 32'hffffffff : (sz == 2'h1 ? 32'hffff : 32'hff) << (8 * ad[1:0]);
    endfunction

    // Reference store; outputs trail it by one edge, answers by one request
    always @(posedge mclk) begin
        up = rst_b ? up + 1 : 0;
        if (up > 2) begin
            cmp_reg(32'({protection_gated_r, stat_r, wo_val_r, ctrl_rwh_r, ctrl_rw_r}),
                    32'({pprt, pmix[27:24], pwo, pmix[15:0]}));
            cmp_reg(gated_cfg_r, pgat);
            cmp_reg(keep_val_r, pkep);
            // Strobe trails its write by one edge, unlike the store copies
            cmp_reg(32'(wo_strobe_r), 32'(wsp));
        end
        if (bus_ack_r === 1'h1) begin
            if (expq.size() == 0) note("answer without request");
            else cmp_bus({bus_err_r, bus_rdata_r}, expq.pop_front());
        end
        {pmix, pgat, pkep, pprt, pwo} = {mix, gat, kep, prt, wo};
        e = bad(bus_addr, bus_size);
        m = lanes(bus_addr, bus_size);
        wsp = rst_b && bus_req && bus_wr && !e && bus_addr[7:2] == 6'h0 && m[20];
        case (bus_addr[7:2])
            6'h0: rd = mix | {12'h0, ro_val, 16'h0};
            6'h1: rd = gat;
            6'h2: rd = kep;
            6'h3: rd = {31'h0, prt};
            default: rd = 32'h0;
        endcase
        if (bus_req === 1'h1) expq.push_back({e, (bus_wr | e) ? 32'h0 : rd});
        if (!rst_b || soft_clr) begin
            {mix, gat, wo, prt} = {32'h0, 32'h0, 4'h0, 1'h1};
            if (!rst_b) kep = 32'h0;
        end else begin
            mix[15:8] = (mix[15:8] | rwh_set) & ~rwh_clr;
            mix[27:24] = (mix[27:24] | stat_set) & ~stat_clr;
            if (bus_req && bus_wr && !e) begin
                case (bus_addr[7:2])
                    6'h0: mix[15:0] = mix[15:0] & ~m[15:0] | bus_wdata[15:0] & m[15:0];
                    6'h1: if (!prt) gat = bus_wdata;
                    6'h2: kep = kep & ~m | bus_wdata & m;
                    6'h3: prt = bus_wdata[0];
                    default: ;
                endcase
                if (bus_addr[7:2] == 6'h0 && m[20]) wo = bus_wdata[23:20];
            end
        end
    end

    initial begin
        repeat (6) @(posedge mclk);
        rst_b <= 1'h1;
        hw_on <= 1'h1;
        // Every range and size, narrow word-only accesses included, hardware busy
        repeat (150) begin
            a = pick[$random(seed) & 7];
            s = 2'($random(seed));
            core.xfer(1'($random(seed)), a, s, $random(seed)
                      & (a == 8'h0 ? 32'h0fffffff : a == 8'h0c ? 32'h1 : 32'hffffffff));
        end
        $display("random traffic done");
        hw_on <= 1'h0;
        for (i = 0; i < 2; i++) begin
            core.xfer(1'h1, `OFS_PROT, `SIZE_WORD, 32'(1 - i));
            core.xfer(1'h1, `OFS_GATED, `SIZE_WORD, $random(seed));
            core.xfer(1'h0, `OFS_GATED, `SIZE_WORD, 32'h0);
        end
        $display("protection test done");
        core.xfer(1'h1, `OFS_KEEP, `SIZE_WORD, $random(seed));
        @(posedge mclk);
        soft_clr <= 1'h1;
        @(posedge mclk);
        soft_clr <= 1'h0;
        for (i = 0; i < 4; i++) core.xfer(1'h0, 8'(4 * i), `SIZE_WORD, 32'h0);
        repeat (4) @(posedge mclk);
        if (expq.size() != 0) note("request left unanswered");
        $display("bank clear test done");
        complete_run;
    end
endmodule
bind regbank regbank_chk u_chk (.*);
`default_nettype wire
